// File: logic/ccd_top.sv
// Clock divider and regulator wake unit with an APB register slave.
// Assumes APB master on CLK_I; the PLL oscillator is modelled by CLK_I itself.
//
// Behaviour
// - Wake outputs high request power, identical pair
// - Wake outputs tell regulator to cut core
// - RTC, USB, Ethernet or reset wake boots
// - Accepted wake event raises wake outputs
// - Start-up waits for active-low power good
// - Buffered input clock, on after reset, gateable
// - PLL multiplier feeds both clock dividers
// - Multiplier changed by write-then-commit sequence; the commit write loads its own data, not the pending value
// - Clock reference at system rate, memory-controller gated
// - Peripherals clocked only from system clock
// - System divider ratio equals field, 1..15
// - System divider changes without PLL relock
// - Core divider selects 1, 2, 4, 8
// - Frequency field zero drops both wake outputs
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`include "ccd_consts.svh"

module ccd_top (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        POWER_GOOD_N_I,
  input  wire logic        RTC_WAKE_I,
  input  wire logic        USB_WAKE_I,
  input  wire logic        ETH_WAKE_I,
  input  wire logic        SDRAM_REF_EN_I,
  input  wire logic        ASYNC_REF_EN_I,
  output logic             WAKE_OUT_A_O,
  output logic             WAKE_OUT_B_O,
  output logic             BUFFERED_CLOCK_OUT_O,
  output logic             CORE_CLOCK_EN_O,
  output logic             SYS_CLOCK_EN_O,
  output logic             SYSTEM_CLOCK_REF_OUT_O,
  output logic      [5:0]  PLL_MULT_O,
  output logic             PLL_LOCKED_O,
  output logic             BOOT_START_O,
  output logic             CORE_RUN_O
);
  import ccd_pkg::*;

  localparam int LOCK_CYC = `CCD_LOCK_CYC;
  localparam logic [6:0] LOCK_LOAD = 7'(`CCD_LOCK_CYC);

  logic        rst_s1;
  logic        rst_n;
  ccd_regctl_t regctl;
  ccd_regctl_t next_regctl;
  ccd_div_t    divsel;
  ccd_div_t    next_divsel;
  logic [5:0]  mult_pend;
  logic [5:0]  next_mult_pend;
  logic [5:0]  mult_act;
  logic [5:0]  next_mult_act;
  logic [6:0]  lock_cnt;
  logic [6:0]  next_lock_cnt;
  logic [31:0] next_prdata;
  logic        ref_out;
  logic        next_ref_out;
  logic        buf_en_lat;
  logic        wr;
  logic        sys_tick;
  logic        core_tick;
  logic        wake;
  logic        boot;
  logic        restore;
  logic        wake_ev;
  ccd_wake_t   wstate;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `CCD_ADDR_REGCTL) || (a == `CCD_ADDR_DIV) ||
             (a == `CCD_ADDR_PLL) || (a == `CCD_ADDR_STAT);
  endfunction

  // Refuses unmapped addresses, status writes and a zero system ratio
  function automatic logic refused(input logic [7:0] a, input logic w, input logic [31:0] d);
    refused = !mapped(a) || (w && a == `CCD_ADDR_STAT) ||
              (w && a == `CCD_ADDR_DIV && d[3:0] == 4'h0);
  endfunction

  // Second stage is the only reader of the first
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  assign wr        = PSEL_I && PENABLE_I && PWRITE_I && !refused(PADDR_I, 1'b1, PWDATA_I);
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && refused(PADDR_I, PWRITE_I, PWDATA_I);

  always_comb begin
    next_regctl    = regctl;
    next_divsel    = divsel;
    next_mult_pend = mult_pend;
    next_mult_act  = mult_act;
    next_lock_cnt  = (lock_cnt == 7'h00) ? lock_cnt : lock_cnt - 7'h01;
    if (wr && PADDR_I == `CCD_ADDR_REGCTL) begin
      next_regctl = PWDATA_I[5:0];
    end
    if (wr && PADDR_I == `CCD_ADDR_DIV) begin
      next_divsel = PWDATA_I[5:0];
    end
    if (wr && PADDR_I == `CCD_ADDR_PLL) begin
      next_mult_pend = PWDATA_I[5:0];
      if (PWDATA_I[`CCD_PLL_GO_BIT]) begin
        next_mult_act = PWDATA_I[5:0];
        next_lock_cnt = LOCK_LOAD;
      end
    end
    // A wake brings the regulator back to its default level
    if (restore) begin
      next_regctl.regulator_frequency_field = `CCD_REGULATOR_FREQUENCY_FIELD_RST;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      regctl    <= `CCD_REGCTL_RST;
      divsel    <= `CCD_DIV_RST;
      mult_pend <= `CCD_MULT_RST;
      mult_act  <= `CCD_MULT_RST;
      lock_cnt  <= 7'h00;
    end else begin
      regctl    <= next_regctl;
      divsel    <= next_divsel;
      mult_pend <= next_mult_pend;
      mult_act  <= next_mult_act;
      lock_cnt  <= next_lock_cnt;
    end
  end

  always_comb begin
    next_prdata = PRDATA_O;
    if (PSEL_I && !PENABLE_I) begin
      next_prdata = 32'h0000_0000;
      unique case (PADDR_I)
        `CCD_ADDR_REGCTL: next_prdata[5:0] = regctl;
        `CCD_ADDR_DIV:    next_prdata[5:0] = divsel;
        `CCD_ADDR_PLL:    next_prdata[5:0] = mult_pend;
        `CCD_ADDR_STAT:   next_prdata[9:0] = {mult_act, !POWER_GOOD_N_I, wstate,
                                              lock_cnt == 7'h00};
        default:          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // System divider keeps running through a PLL relock
  ccd_div #(.W(4)) u_sys_div (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .ratio_i (divsel.sys),
    .tick_o  (sys_tick)
  );

  ccd_div #(.W(4)) u_core_div (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .ratio_i (4'h1 << divsel.core),
    .tick_o  (core_tick)
  );

  assign wake_ev = (RTC_WAKE_I && regctl.rtc_wen) || (USB_WAKE_I && regctl.usb_wen) ||
                   (ETH_WAKE_I && regctl.eth_wen);

  ccd_wake u_wake (
    .clk_i          (CLK_I),
    .rst_n_i        (rst_n),
    .hib_req_i      (regctl.regulator_frequency_field == `CCD_REGULATOR_FREQUENCY_FIELD_OFF),
    .wake_ev_i      (wake_ev),
    .power_good_n_i (POWER_GOOD_N_I),
    .state_o        (wstate),
    .wake_o         (wake),
    .boot_o         (boot),
    .restore_o      (restore)
  );

  assign next_ref_out = sys_tick && (SDRAM_REF_EN_I || ASYNC_REF_EN_I);

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA_O     <= 32'h0000_0000;
      ref_out      <= 1'b0;
      WAKE_OUT_A_O <= 1'b1;
      WAKE_OUT_B_O <= 1'b1;
      BOOT_START_O <= 1'b0;
      CORE_RUN_O   <= 1'b0;
    end else begin
      PRDATA_O     <= next_prdata;
      ref_out      <= next_ref_out;
      WAKE_OUT_A_O <= wake;
      WAKE_OUT_B_O <= wake;
      BOOT_START_O <= boot;
      CORE_RUN_O   <= (wstate == CCD_RUN);
    end
  end

  // Enable latched while the clock is low so the gated copy never glitches
  always_ff @(negedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      buf_en_lat <= 1'b1;
    end else begin
      buf_en_lat <= regctl.buf_en;
    end
  end

  assign BUFFERED_CLOCK_OUT_O   = CLK_I && buf_en_lat;
  assign CORE_CLOCK_EN_O        = core_tick;
  assign SYS_CLOCK_EN_O         = sys_tick;
  assign SYSTEM_CLOCK_REF_OUT_O = ref_out;
  assign PLL_MULT_O             = mult_act;
  assign PLL_LOCKED_O           = (lock_cnt == 7'h00);

  pll_relock_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (wr && PADDR_I == `CCD_ADDR_PLL && PWDATA_I[`CCD_PLL_GO_BIT])
      |=> !PLL_LOCKED_O ##LOCK_CYC PLL_LOCKED_O)
    else $error("pll lock time wrong");
  sys_div_write_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (wr && PADDR_I == `CCD_ADDR_DIV) |=> divsel.sys == $past(PWDATA_I[3:0]))
    else $error("system divider write not applied at once");
  zero_ratio_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    divsel.sys != 4'h0)
    else $error("illegal zero system ratio stored");
  ref_gate_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!SDRAM_REF_EN_I && !ASYNC_REF_EN_I) |=> !SYSTEM_CLOCK_REF_OUT_O)
    else $error("clock reference ran while disabled");
  wake_pair_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    WAKE_OUT_A_O == WAKE_OUT_B_O)
    else $error("wake outputs differ");
  regulator_frequency_field_off_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (wstate == CCD_RUN && regctl.regulator_frequency_field == `CCD_REGULATOR_FREQUENCY_FIELD_OFF) |=> ##1 !WAKE_OUT_A_O)
    else $error("shutdown did not drop wake outputs");

  // Refused writes must leave divsel and mult_pend alone
  refused_write_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (PSEL_I && PENABLE_I && PWRITE_I && PSLVERR_O)
      |=> $stable(divsel) && $stable(mult_pend))
    else $error("refused write changed a register");

  restore_regulator_frequency_field_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    restore |=> regctl.regulator_frequency_field == `CCD_REGULATOR_FREQUENCY_FIELD_RST)
    else $error("wake did not restore regulator level");

  // Multiplier only reaches the PLL on a commit, which loads the commit write's own data, not the pending value
  pll_pend_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (wr && PADDR_I == `CCD_ADDR_PLL) |=> mult_pend == $past(PWDATA_I[5:0]))
    else $error("pending multiplier not stored");

  mult_hold_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !(wr && PADDR_I == `CCD_ADDR_PLL && PWDATA_I[`CCD_PLL_GO_BIT]) |=> $stable(PLL_MULT_O))
    else $error("multiplier changed without commit");

  mult_commit_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (wr && PADDR_I == `CCD_ADDR_PLL && PWDATA_I[`CCD_PLL_GO_BIT])
      |=> PLL_MULT_O == $past(PWDATA_I[5:0]))
    else $error("committed multiplier not applied");

  // Reference is a delayed copy of the system enable, gated by the two reference enables
  ref_follow_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    SYSTEM_CLOCK_REF_OUT_O |-> $past(SYS_CLOCK_EN_O))
    else $error("clock reference off the system rate");

  ref_on_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (rst_n && SYS_CLOCK_EN_O && (SDRAM_REF_EN_I || ASYNC_REF_EN_I))
      |=> SYSTEM_CLOCK_REF_OUT_O)
    else $error("clock reference missing while enabled");

  // Ratio one must give an enable on every cycle
  sys_ratio_one_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (SYS_CLOCK_EN_O && divsel.sys == 4'h1) |=> SYS_CLOCK_EN_O)
    else $error("system ratio one skipped a cycle");

  // Guard on reset too: the release edge still clears the counters
  core_ratio_two_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (rst_n && CORE_CLOCK_EN_O && divsel.core == 2'h1)
      |=> !CORE_CLOCK_EN_O ##1 CORE_CLOCK_EN_O)
    else $error("core ratio two period wrong");

  hib_hold_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (wstate == CCD_HIB && !wake_ev)
      |=> wstate == CCD_HIB && !WAKE_OUT_A_O && !WAKE_OUT_B_O)
    else $error("hibernate left without a wake");

  // Boot may follow only a good supply two cycles earlier
  boot_gate_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    $rose(BOOT_START_O) |-> $past(POWER_GOOD_N_I, 2) == 1'b0)
    else $error("boot without power good");

  run_after_boot_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    $rose(CORE_RUN_O) |-> $past(BOOT_START_O))
    else $error("core ran without a boot");
endmodule

// File: logic/ccd_consts.svh
// Register offsets, reset values, field positions and timing counts of the clock unit.
// Assumes a 25 MHz system clock and 32-bit APB data with word-aligned registers.
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

`define CCD_ADDR_REGCTL 8'h00
`define CCD_ADDR_DIV    8'h04
`define CCD_ADDR_PLL    8'h08
`define CCD_ADDR_STAT   8'h0c

`define CCD_REGCTL_RST  6'h07
`define CCD_DIV_RST     6'h05
`define CCD_MULT_RST    6'h0a
`define CCD_REGULATOR_FREQUENCY_FIELD_RST    2'h3
`define CCD_REGULATOR_FREQUENCY_FIELD_OFF    2'h0
`define CCD_PLL_GO_BIT  8

`define CCD_CLK_NS      40
`define CCD_LOCK_NS     2000
`define CCD_LOCK_CYC    ((`CCD_LOCK_NS + `CCD_CLK_NS - 1) / `CCD_CLK_NS)

`endif

// File: logic/ccd_pkg.sv
// Types shared by the clock and wake unit.
// Assumes ccd_consts.svh carries all numeric constants.
package ccd_pkg;
  typedef enum logic [1:0] {
    CCD_RUN   = 2'b00,
    CCD_HIB   = 2'b01,
    CCD_PWRUP = 2'b11,
    CCD_BOOT  = 2'b10
  } ccd_wake_t;

  typedef struct packed {
    logic       eth_wen;
    logic       usb_wen;
    logic       rtc_wen;
    logic       buf_en;
    logic [1:0] regulator_frequency_field;
  } ccd_regctl_t;

  typedef struct packed {
    logic [1:0] core;
    logic [3:0] sys;
  } ccd_div_t;
endpackage

// File: logic/ccd_div.sv
// Ratio divider producing a one-cycle tick every ratio_i input clocks.
// Assumes ratio_i is at least one; a new ratio is adopted only at a wrap.
module ccd_div #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] ratio_i,
  output logic              tick_o
);
  import ccd_pkg::*;

  logic [W-1:0] cnt;
  logic [W-1:0] act;
  logic [W-1:0] next_cnt;
  logic [W-1:0] next_act;

  // Ratio only changes at a wrap so no period is ever cut short
  always_comb begin
    next_cnt = cnt - {{(W-1){1'b0}}, 1'b1};
    next_act = act;
    if (cnt == '0) begin
      next_act = ratio_i;
      next_cnt = ratio_i - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      act <= {{(W-1){1'b0}}, 1'b1};
    end else begin
      cnt <= next_cnt;
      act <= next_act;
    end
  end

  assign tick_o = (cnt == '0);

  ratio_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tick_o |=> act == $past(act))
    else $error("divider ratio changed mid period");
  // Reset sampled too: the release edge itself still clears the counter
  tick_spacing_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rst_n_i && tick_o) |=> cnt == $past(ratio_i) - {{(W-1){1'b0}}, 1'b1})
    else $error("divider reload does not match ratio");
endmodule

// File: logic/ccd_wake.sv
// Hibernate and wake sequencer driving the external regulator request.
// Assumes wake events are already gated by their enables and power_good_n is synchronous.
module ccd_wake (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              hib_req_i,
  input  wire logic              wake_ev_i,
  input  wire logic              power_good_n_i,
  output ccd_pkg::ccd_wake_t     state_o,
  output logic                   wake_o,
  output logic                   boot_o,
  output logic                   restore_o
);
  import ccd_pkg::*;

  ccd_wake_t state;
  ccd_wake_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      CCD_RUN:   if (hib_req_i) next_state = CCD_HIB;
      CCD_HIB:   if (wake_ev_i) next_state = CCD_PWRUP;
      CCD_PWRUP: if (!power_good_n_i) next_state = CCD_BOOT;
      CCD_BOOT:  next_state = CCD_RUN;
    endcase
  end

  // Reset lands in power-up, so a reset is itself a wake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= CCD_PWRUP;
    end else begin
      state <= next_state;
    end
  end

  assign state_o   = state;
  assign wake_o    = (state != CCD_HIB);
  assign boot_o    = (state == CCD_BOOT);
  assign restore_o = (state == CCD_HIB) && wake_ev_i;

  hib_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == CCD_RUN && hib_req_i) |=> !wake_o)
    else $error("wake request stayed high after shutdown");
  wake_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == CCD_HIB && wake_ev_i) |=> wake_o && state == CCD_PWRUP)
    else $error("wake event did not raise the regulator request");
  pg_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == CCD_PWRUP && power_good_n_i) |=> !boot_o)
    else $error("boot started before power good");
  boot_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(boot_o) |=> !boot_o && state == CCD_RUN)
    else $error("boot pulse not single cycle");
endmodule

// File: tb/ccd_reg_model.sv
// Behavioural external core regulator for the clock unit bench.
// Assumes level wake requests; answers with an active-low power good.
module ccd_reg_model #(
  parameter int DELAY = 8
) (
  input  wire logic clk_i,
  input  wire logic wake_a_i,
  input  wire logic wake_b_i,
  output logic      power_good_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial power_good_n_o = 1'b1;
  // Ramps only while asked; drops at once so the unit sees no stale good level
  always @(posedge clk_i) begin
    if (!(wake_a_i || wake_b_i)) begin
      cnt <= 0;
      power_good_n_o <= 1'b1;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end else begin
      power_good_n_o <= 1'b0;
    end
  end
endmodule

// File: tb/tb_core_system_clock_divider.sv
// Self-checking bench for the clock divider and regulator wake unit.
// Assumes ccd_top answers APB with zero wait states and a regulator model.
`include "ccd_consts.svh"
module tb_core_system_clock_divider;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_I = 1'b0, NRST_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [7:0]  PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rdat;
  logic        PREADY_O, PSLVERR_O, POWER_GOOD_N_I, err, SDRAM_REF_EN_I = 1'b1;
  logic        ASYNC_REF_EN_I = 1'b0, WAKE_OUT_A_O, WAKE_OUT_B_O, BUFFERED_CLOCK_OUT_O;
  logic        CORE_CLOCK_EN_O, SYS_CLOCK_EN_O, SYSTEM_CLOCK_REF_OUT_O;
  logic        PLL_LOCKED_O, BOOT_START_O, CORE_RUN_O;
  logic [5:0]  PLL_MULT_O;
  logic [2:0]  wk = 3'h0;
  int          n_mismatch = 0, checks = 0, n;
  int          sl[4] = '{1, 6, 10, 15};

  ccd_top DUT (.CLK_I, .NRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .POWER_GOOD_N_I, .RTC_WAKE_I(wk[0]),
    .USB_WAKE_I(wk[1]), .ETH_WAKE_I(wk[2]), .SDRAM_REF_EN_I, .ASYNC_REF_EN_I,
    .WAKE_OUT_A_O, .WAKE_OUT_B_O, .BUFFERED_CLOCK_OUT_O, .CORE_CLOCK_EN_O,
    .SYS_CLOCK_EN_O, .SYSTEM_CLOCK_REF_OUT_O, .PLL_MULT_O, .PLL_LOCKED_O,
    .BOOT_START_O, .CORE_RUN_O);
  ccd_reg_model #(.DELAY(8)) u_reg (.clk_i(CLK_I), .wake_a_i(WAKE_OUT_A_O),
    .wake_b_i(WAKE_OUT_B_O), .power_good_n_o(POWER_GOOD_N_I));

  initial forever #20 CLK_I = ~CLK_I;

  function automatic logic sg(input int s);
    case (s)
      0: return CORE_CLOCK_EN_O;
      1: return SYS_CLOCK_EN_O;
      2: return SYSTEM_CLOCK_REF_OUT_O;
      3: return WAKE_OUT_A_O;
      4: return CORE_RUN_O;
      5: return PLL_LOCKED_O;
      default: return BOOT_START_O;
    endcase
  endfunction

  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Outputs are read straight after the edge, before that edge's updates land
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (sg(s) !== v && n < lim);
    if (sg(s) !== v) begin
      chk(0, "wait timed out");
      end_of_test();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK_I);
      k++;
    end while (PREADY_O !== 1'b1 && k < 16);
    rdat = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    if (PREADY_O !== 1'b1) begin
      chk(0, "no ready");
      end_of_test();
    end
    @(posedge CLK_I);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk(err === e, $sformatf("write %h response", a));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0);
    chk(err === e && rdat === x, $sformatf("read %h got %h", a, rdat));
  endtask

  // Two warm-up ticks flush a ratio that was still in flight
  task automatic per(input int s, input int x);
    repeat (3) wait_for(s, 1'b1, 40);
    chk(n == x, $sformatf("enable %0d period %0d", s, n));
  endtask

  always @(negedge CLK_I) begin
    if (NRST_I) chk(WAKE_OUT_A_O === WAKE_OUT_B_O, "wake pair differs");
  end

  initial begin
    repeat (12) @(posedge CLK_I);
    NRST_I <= 1'b1;
    wait_for(6, 1'b1, 80);
    chk(CORE_RUN_O === 1'b0 && POWER_GOOD_N_I === 1'b0, "boot early");
    wait_for(4, 1'b1, 3);
    rd(`CCD_ADDR_REGCTL, 32'h07, 0);
    rd(`CCD_ADDR_DIV, 32'h05, 0);
    rd(`CCD_ADDR_PLL, 32'h0a, 0);
    rd(`CCD_ADDR_STAT, 32'ha9, 0);
    rd(8'h10, 32'h0, 1);
    wr(`CCD_ADDR_STAT, 32'h0, 1);
    wr(`CCD_ADDR_DIV, 32'h20, 1);
    rd(`CCD_ADDR_DIV, 32'h05, 0);
    per(1, 5);
    for (int i = 0; i < 4; i++) begin
      wr(`CCD_ADDR_DIV, (i << 4) | sl[i], 0);
      per(1, sl[i]);
      per(0, 1 << i);
    end
    per(2, 15);
    SDRAM_REF_EN_I <= 1'b0;
    ASYNC_REF_EN_I <= 1'b1;
    per(2, 15);
    ASYNC_REF_EN_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    repeat (40) begin
      @(posedge CLK_I);
      chk(SYSTEM_CLOCK_REF_OUT_O === 1'b0, "reference not gated");
    end
    #5 chk(BUFFERED_CLOCK_OUT_O === 1'b1, "buffered clock off");
    @(posedge CLK_I);
    wr(`CCD_ADDR_REGCTL, 32'h03, 0);
    @(posedge CLK_I);
    #5 chk(BUFFERED_CLOCK_OUT_O === 1'b0, "buffered clock on");
    @(posedge CLK_I);
    wr(`CCD_ADDR_REGCTL, 32'h07, 0);
    wr(`CCD_ADDR_PLL, 32'h0c, 0);
    chk(PLL_MULT_O === 6'h0a, "multiplier changed early");
    wr(`CCD_ADDR_PLL, 32'h10c, 0);
    chk(PLL_LOCKED_O === 1'b0, "no relock");
    wait_for(5, 1'b1, 60);
    chk(n >= 40 && PLL_MULT_O === 6'h0c, "relock time or multiplier");
    rd(`CCD_ADDR_STAT, 32'hc9, 0);
    for (int i = 0; i < 3; i++) begin
      wr(`CCD_ADDR_REGCTL, 32'h04 | (32'h08 << i), 0);
      wait_for(3, 1'b0, 4);
      chk(WAKE_OUT_B_O === 1'b0, "shutdown request");
      rd(`CCD_ADDR_STAT, 32'hc3, 0);
      wk <= 3'h1 << ((i + 1) % 3);
      repeat (4) @(posedge CLK_I);
      chk(WAKE_OUT_A_O === 1'b0, "disabled source woke");
      wk <= 3'h1 << i;
      wait_for(3, 1'b1, 4);
      chk(WAKE_OUT_B_O === 1'b1 && CORE_RUN_O === 1'b0, "wake request");
      wk <= 3'h0;
      wait_for(6, 1'b1, 40);
      wait_for(4, 1'b1, 3);
      rd(`CCD_ADDR_REGCTL, 32'h07 | (32'h08 << i), 0);
    end
    wr(`CCD_ADDR_REGCTL, 32'h04, 0);
    wait_for(3, 1'b0, 4);
    NRST_I <= 1'b0;
    @(posedge CLK_I);
    #5 chk(WAKE_OUT_A_O === 1'b1 && WAKE_OUT_B_O === 1'b1, "reset wake");
    @(posedge CLK_I);
    NRST_I <= 1'b1;
    wait_for(6, 1'b1, 80);
    end_of_test();
  end
endmodule
